//--- safety_card_cfg.svh
// Offsets, field positions and reset values of the safety card error block
`ifndef SAFETY_CARD_CFG_SVH
`define SAFETY_CARD_CFG_SVH
// ****************************************************************
// Register byte addresses
// ****************************************************************
`define REG_CONTROL        12'h000
`define REG_STATUS         12'h004
`define REG_FAULT_SET      12'h008
`define REG_MODULE_ACK     12'h00c
`define REG_IMAGE_FLAGS    12'h010
`define REG_ENC_ANGLE      12'h014
`define REG_TORQUE_CUR     12'h018
`define REG_FIELD_CUR      12'h01c
`define REG_DRIVE_REQ      12'h020
`define REG_SAFE_ADDR      12'h024
`define REG_IMAGE_SIZE     12'h028
// ****************************************************************
// Field positions
// ****************************************************************
`define CTRL_TORQUE_EN_BIT 0
`define FLT_TRANSIENT_BIT  0
`define FLT_INTEGRITY_BIT  1
`define FLT_ENC_LIFE_BIT   2
`define FLT_SELFDIAG_BIT   3
`define IMG_PATH_ERR_BIT   0
`define IMG_AXIS_EN_BIT    1
`define IMG_BRAKE_ERR_BIT  2
`define IMG_BRAKE_REQ_BIT  3
`define IMG_ENC_LOW_BIT    16
`define IMG_ENC_HIGH_BIT   17
`define IMG_ENC_ERR_BIT    18
`define IMG_ENC_ON_BIT     19
`define DRV_RUN_BIT        0
`define DRV_ACK_BIT        1
// ****************************************************************
// Reset values and sizes
// ****************************************************************
`define SAFE_ADDR_RESET    16'h0001
`define IMAGE_IN_BYTES     8'h07
`define IMAGE_OUT_BYTES    8'h07
`define IMAGE_USAGE_BYTES  8'h02
`define MODULE_COUNT       4
`endif

//--- safety_card_pkg.sv
// Types of the safety card error block
package safety_card_pkg;
    typedef enum logic [1:0] {
        CARD_RUN      = 2'b00,
        CARD_SHUTDOWN = 2'b01,
        CARD_FAULT    = 2'b10
    } card_state_t;
    typedef logic [3:0] module_mask_t;
endpackage

//--- input_sync.sv
// Two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/10ps
module input_sync #(
    parameter int WIDTH = 1
) (
    // System
    input  wire logic             clock,
    input  wire logic             rst_n,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

//--- safety_card_error_state.sv
// Fault reaction state and process image mapping of a drive safety card
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`include "safety_card_cfg.svh"
// Function
// - Self-diagnosis fault forces safe torque state
// - Transient fault enters whole-card shutdown
// - Shutdown left only by power-on reset or by an integrity error
// - Integrity error enters permanent fault
// - Software error shuts only that module
// - Acknowledge request clears module shutdown (here only while card_state is CARD_RUN)
// - Encoder service life expiry raises error
// - Safe address is 1 after delivery
// - Input image 7 bytes, 2 usage
// - Output image 7 bytes, 2 usage
// - Input bit 0.0 enables torque outputs
// - Output bit 0.0 reports torque-off state
// - Local bit 0.0 flags switch-off path error
// - Local bit 0.1 true while axis enabled
// - Local bit 0.2 flags brake control error
// - Bits 2.0-2.2 flag encoder supply errors
// - Bytes 4-5 encoder supply millivolts
// - Bytes 6-7 rotor electrical angle
// - Bytes 8-15 torque and field currents
// - Bits 16.0, 16.1 mirror run, acknowledge
module safety_card_error_state (
    // System
    input  wire logic                         clock,
    input  wire logic                         rst_n,
    // APB slave
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [11:0]                  paddr,
    input  wire logic [31:0]                  pwdata,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    // Fault detectors (pins)
    input  wire logic                         supply_fault_in,
    input  wire logic                         integrity_fault_in,
    input  wire logic                         selfdiag_fault_in,
    input  wire logic                         encoder_life_expired_in,
    input  wire logic [3:0]                   module_sw_fault_in,
    // Drive and path status (pins)
    input  wire logic                         switch_off_path_error,
    input  wire logic                         brake_control_error,
    input  wire logic                         drive_brake_release_request,
    input  wire logic                         encoder_supply_low_flag,
    input  wire logic                         encoder_supply_high_flag,
    input  wire logic                         encoder_supply_error_flag,
    input  wire logic                         drive_encoder_on_request,
    input  wire logic [15:0]                  encoder_supply_millivolts,
    input  wire logic [15:0]                  rotor_electrical_angle,
    input  wire logic [31:0]                  torque_current_value,
    input  wire logic [31:0]                  field_current_value,
    input  wire logic                         drive_run_bit,
    input  wire logic                         drive_error_ack_bit,
    // Outputs
    output logic                              torque_path1_enable,
    output logic                              torque_path2_enable,
    output logic                              torque_off_state_report,
    output safety_card_pkg::card_state_t      card_state,
    output safety_card_pkg::module_mask_t     module_shutdown
);
    import safety_card_pkg::*;

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    localparam int SYNC_W = 24 + 96;
    logic [SYNC_W-1:0] raw_in;
    logic [SYNC_W-1:0] sync_in;

    assign raw_in = {supply_fault_in, integrity_fault_in, selfdiag_fault_in, encoder_life_expired_in,
                     module_sw_fault_in, switch_off_path_error, brake_control_error,
                     drive_brake_release_request, encoder_supply_low_flag, encoder_supply_high_flag,
                     encoder_supply_error_flag, drive_encoder_on_request, drive_run_bit,
                     drive_error_ack_bit, 7'h0, encoder_supply_millivolts, rotor_electrical_angle,
                     torque_current_value, field_current_value};

    input_sync #(
        .WIDTH    (SYNC_W)
    ) u_sync (
        .clock    (clock),
        .rst_n    (rst_n),
        .async_in (raw_in),
        .sync_out (sync_in)
    );

    wire logic        s_transient   = sync_in[119];
    wire logic        s_integrity   = sync_in[118];
    wire logic        s_selfdiag    = sync_in[117];
    wire logic        s_enc_life    = sync_in[116];
    wire logic [3:0]  s_module_err  = sync_in[115:112];
    wire logic        s_path_err    = sync_in[111];
    wire logic        s_brake_err   = sync_in[110];
    wire logic        s_brake_req   = sync_in[109];
    wire logic        s_enc_low     = sync_in[108];
    wire logic        s_enc_high    = sync_in[107];
    wire logic        s_enc_err     = sync_in[106];
    wire logic        s_enc_on      = sync_in[105];
    wire logic        s_run         = sync_in[104];
    wire logic        s_ack         = sync_in[103];
    wire logic [15:0] s_enc_mv      = sync_in[95:80];
    wire logic [15:0] s_angle       = sync_in[79:64];
    wire logic [31:0] s_iq          = sync_in[63:32];
    wire logic [31:0] s_id          = sync_in[31:0];

    // ****************************************************************
    // Register bus decode
    // ****************************************************************
    logic        torque_req_q;
    logic        torque_req_d;
    logic [3:0]  sw_fault_q;
    logic [3:0]  sw_fault_d;
    logic [15:0] safe_addr_q;
    logic [15:0] safe_addr_d;
    logic        ack_prev_q;
    card_state_t state_d;
    logic [3:0]  mod_d;

    wire logic access    = psel && penable;
    wire logic wr_access = access && pwrite;
    wire logic rd_access = access && !pwrite;
    wire logic wr_ctrl   = wr_access && (paddr == `REG_CONTROL);
    wire logic wr_fault  = wr_access && (paddr == `REG_FAULT_SET);
    wire logic wr_ack    = wr_access && (paddr == `REG_MODULE_ACK);
    wire logic wr_addr   = wr_access && (paddr == `REG_SAFE_ADDR);

    function automatic logic addr_mapped(input logic [11:0] a);
        addr_mapped = (a[1:0] == 2'h0) && (a <= `REG_IMAGE_SIZE);
    endfunction

    function automatic logic addr_writable(input logic [11:0] a);
        addr_writable = (a == `REG_CONTROL) || (a == `REG_FAULT_SET) ||
                        (a == `REG_MODULE_ACK) || (a == `REG_SAFE_ADDR);
    endfunction

    // Judged in the setup cycle so the error stands with pready
    wire logic bad_access = psel && !penable && (!addr_mapped(paddr) || (pwrite && !addr_writable(paddr)));

    // ****************************************************************
    // Error sources
    // ****************************************************************
    // Software-injected faults join the pin detectors
    wire logic transient_hit = s_transient || (wr_fault && pwdata[`FLT_TRANSIENT_BIT]);
    wire logic integrity_hit = s_integrity || (wr_fault && pwdata[`FLT_INTEGRITY_BIT]);
    wire logic diag_hit      = s_selfdiag || s_enc_life || (wr_fault && pwdata[`FLT_SELFDIAG_BIT]) ||
                               (wr_fault && pwdata[`FLT_ENC_LIFE_BIT]);

    // Acknowledge from drive control word rising edge or register write
    wire logic       ack_edge  = s_ack && !ack_prev_q;
    wire logic [3:0] ack_mask  = (ack_edge ? 4'hf : 4'h0) | (wr_ack ? pwdata[3:0] : 4'h0);

    // ****************************************************************
    // Card state
    // ****************************************************************
    // Fault is terminal; shutdown returns to run only by reset, integrity error moves it to fault
    always_comb begin
        state_d = card_state;
        unique case (card_state)
            CARD_RUN: begin
                if (integrity_hit) begin
                    state_d = CARD_FAULT;
                end else if (transient_hit || diag_hit) begin
                    state_d = CARD_SHUTDOWN;
                end
            end
            CARD_SHUTDOWN: begin
                if (integrity_hit) begin
                    state_d = CARD_FAULT;
                end else begin
                    state_d = CARD_SHUTDOWN;
                end
            end
            CARD_FAULT: begin
                state_d = CARD_FAULT;
            end
            default: begin
                state_d = CARD_FAULT;
            end
        endcase
    end

    // New software errors win over a simultaneous acknowledge
    assign sw_fault_d = s_module_err;
    assign mod_d      = (card_state == CARD_RUN) ? ((module_shutdown & ~ack_mask) | sw_fault_q) : module_shutdown;

    wire logic card_ok = (state_d == CARD_RUN);
    assign torque_req_d = wr_ctrl ? pwdata[`CTRL_TORQUE_EN_BIT] : torque_req_q;
    wire logic paths_on = card_ok && torque_req_d;
    assign safe_addr_d  = wr_addr ? pwdata[15:0] : safe_addr_q;

    // Reset leaves even the permanent fault: card_state loads CARD_RUN
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            card_state <= CARD_RUN;
            module_shutdown <= 4'h0;
        end else begin
            card_state <= state_d;
            module_shutdown <= mod_d;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            torque_req_q <= 1'b0;
            sw_fault_q   <= 4'h0;
            ack_prev_q   <= 1'b0;
            safe_addr_q  <= `SAFE_ADDR_RESET;
        end else begin
            torque_req_q <= torque_req_d;
            sw_fault_q   <= sw_fault_d;
            ack_prev_q   <= s_ack;
            safe_addr_q  <= safe_addr_d;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            torque_path1_enable     <= 1'b0;
            torque_path2_enable     <= 1'b0;
            torque_off_state_report <= 1'b0;
        end else begin
            torque_path1_enable     <= paths_on;
            torque_path2_enable     <= paths_on;
            torque_off_state_report <= paths_on;
        end
    end

    // ****************************************************************
    // Process image read mux
    // ****************************************************************
    logic [31:0] img_flags;
    always_comb begin
        img_flags = 32'h0;
        img_flags[`IMG_PATH_ERR_BIT]  = s_path_err;
        img_flags[`IMG_AXIS_EN_BIT]   = torque_path1_enable;
        img_flags[`IMG_BRAKE_ERR_BIT] = s_brake_err;
        img_flags[`IMG_BRAKE_REQ_BIT] = s_brake_req;
        img_flags[`IMG_ENC_LOW_BIT]   = s_enc_low;
        img_flags[`IMG_ENC_HIGH_BIT]  = s_enc_high;
        img_flags[`IMG_ENC_ERR_BIT]   = s_enc_err;
        img_flags[`IMG_ENC_ON_BIT]    = s_enc_on;
    end

    wire logic [31:0] status_word = {24'h0, module_shutdown, 1'b0, torque_off_state_report, card_state};
    wire logic [31:0] drive_word  = {30'h0, s_ack, s_run};
    wire logic [31:0] angle_word  = {s_angle, s_enc_mv};
    wire logic [31:0] size_word   = {8'h0, `IMAGE_USAGE_BYTES, `IMAGE_OUT_BYTES, `IMAGE_IN_BYTES};

    logic [31:0] rd_mux;
    always_comb begin
        unique case (paddr)
            `REG_CONTROL:     rd_mux = {31'h0, torque_req_q};
            `REG_STATUS:      rd_mux = status_word;
            `REG_MODULE_ACK:  rd_mux = {28'h0, module_shutdown};
            `REG_IMAGE_FLAGS: rd_mux = img_flags;
            `REG_ENC_ANGLE:   rd_mux = angle_word;
            `REG_TORQUE_CUR:  rd_mux = s_iq;
            `REG_FIELD_CUR:   rd_mux = s_id;
            `REG_DRIVE_REQ:   rd_mux = drive_word;
            `REG_SAFE_ADDR:   rd_mux = {16'h0, safe_addr_q};
            `REG_IMAGE_SIZE:  rd_mux = size_word;
            default:          rd_mux = 32'h0;
        endcase
    end

    // ****************************************************************
    // APB answer
    // ****************************************************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= (psel && !penable && !pwrite) ? rd_mux : (rd_access ? prdata : 32'h0);
            pready  <= psel && !penable;
            pslverr <= bad_access;
        end
    end
endmodule

//--- safety_card_chk.sv
// Port assertions of the safety card error state block
`timescale 1ns/10ps
module safety_card_chk
    import safety_card_pkg::*;
(
    // System
    input wire logic                          clock,
    input wire logic                          rst_n,
    // APB
    input wire logic                          psel,
    input wire logic                          penable,
    input wire logic                          pready,
    input wire logic                          pslverr,
    // Fault pins
    input wire logic                          supply_fault_in,
    input wire logic                          integrity_fault_in,
    input wire logic                          selfdiag_fault_in,
    input wire logic                          encoder_life_expired_in,
    input wire logic [3:0]                    module_sw_fault_in,
    // Outputs
    input wire logic                          torque_path1_enable,
    input wire logic                          torque_path2_enable,
    input wire logic                          torque_off_state_report,
    input wire safety_card_pkg::card_state_t  card_state,
    input wire safety_card_pkg::module_mask_t module_shutdown
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // ****************************************************************
    // Bus answer
    // ****************************************************************
    setup_answer_a: assert property (psel && !penable |=> pready && psel && penable)
        else $error("pready missing one cycle after setup");
    error_pair_a: assert property (pslverr |-> pready && psel && penable)
        else $error("pslverr outside an answered access");
    // ****************************************************************
    // Card states
    // ****************************************************************
    transient_entry_a: assert property (supply_fault_in [*4] |-> card_state != CARD_RUN)
        else $error("transient fault did not stop the card");
    selfdiag_entry_a: assert property (selfdiag_fault_in [*4] |-> card_state != CARD_RUN)
        else $error("self-diagnosis fault did not stop the card");
    life_entry_a: assert property (encoder_life_expired_in [*4] |-> card_state != CARD_RUN)
        else $error("encoder life expiry gave no reaction");
    integrity_entry_a: assert property (integrity_fault_in [*4] |-> card_state == CARD_FAULT)
        else $error("integrity error did not give permanent fault");
    shutdown_hold_a: assert property (card_state == CARD_SHUTDOWN |=> card_state != CARD_RUN)
        else $error("shutdown left without reset");
    fault_hold_a: assert property (card_state == CARD_FAULT |=> card_state == CARD_FAULT)
        else $error("permanent fault left without reset");
    module_entry_a: assert property (module_sw_fault_in[2] [*5] ##0 card_state == CARD_RUN
        |-> module_shutdown[2])
        else $error("module software fault not flagged");
    // ****************************************************************
    // Outputs
    // ****************************************************************
    safe_outputs_a: assert property (card_state != CARD_RUN
        |=> !torque_path1_enable && !torque_path2_enable && !torque_off_state_report)
        else $error("torque paths enabled in a card error state");
    report_pair_a: assert property (torque_off_state_report == (torque_path1_enable && torque_path2_enable))
        else $error("torque-off report disagrees with path enables");
endmodule
bind safety_card_error_state safety_card_chk u_safety_card_chk (
    .clock, .rst_n, .psel, .penable, .pready, .pslverr, .supply_fault_in, .integrity_fault_in,
    .selfdiag_fault_in, .encoder_life_expired_in, .module_sw_fault_in, .torque_path1_enable,
    .torque_path2_enable, .torque_off_state_report, .card_state, .module_shutdown);

//--- drive_fw_model.sv
// Drive firmware model: status levels, control word bits and analog values
`timescale 1ns/10ps
module drive_fw_model (
    // System
    input  wire logic        clock,
    // Scenario pattern
    input  wire logic [7:0]  pat,
    // Drive side levels and values
    output logic      [8:0]  fl,
    output logic      [15:0] mv,
    output logic      [15:0] ang,
    output logic      [31:0] iq,
    output logic      [31:0] id
);
    // Levels change just after the edge, as firmware writes do
    always_ff @(posedge clock) begin
        fl  <= {pat[0], pat};
        mv  <= {pat, ~pat};
        ang <= {~pat, pat};
        iq  <= {pat, 8'h80, ~pat, 8'h01};
        id  <= {~pat, 8'h7f, pat, 8'hfe};
    end
endmodule

//--- test_safety_card_error_state.sv
// Self-checking bench of the safety card error state block
`timescale 1ns/10ps
`include "safety_card_cfg.svh"
module test_safety_card_error_state;
    import safety_card_pkg::*;
    logic         clock = 1'b0, rst_n = 1'b0;
    logic         psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [11:0]  paddr = 12'h000;
    logic [31:0]  pwdata = 32'h0, prdata, iq, id;
    logic         supply_fault_in = 1'b0, integrity_fault_in = 1'b0;
    logic         selfdiag_fault_in = 1'b0, encoder_life_expired_in = 1'b0;
    logic [3:0]   module_sw_fault_in = 4'h0;
    logic [7:0]   pat = 8'h00;
    logic [8:0]   fl;
    logic [15:0]  mv, ang;
    logic         torque_path1_enable, torque_path2_enable, torque_off_state_report;
    card_state_t  card_state;
    module_mask_t module_shutdown;
    int           err_count = 0, n_checks = 0, cyc_n = 0;
    safety_card_error_state u_safety_card_error_state (
        .clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .supply_fault_in, .integrity_fault_in, .selfdiag_fault_in, .encoder_life_expired_in,
        .module_sw_fault_in, .switch_off_path_error(fl[0]), .brake_control_error(fl[1]),
        .drive_brake_release_request(fl[2]), .encoder_supply_low_flag(fl[3]),
        .encoder_supply_high_flag(fl[4]), .encoder_supply_error_flag(fl[5]),
        .drive_encoder_on_request(fl[6]), .encoder_supply_millivolts(mv),
        .rotor_electrical_angle(ang), .torque_current_value(iq), .field_current_value(id),
        .drive_run_bit(fl[7]), .drive_error_ack_bit(fl[8]), .torque_path1_enable,
        .torque_path2_enable, .torque_off_state_report, .card_state, .module_shutdown);
    drive_fw_model u_drive_fw_model (.clock, .pat, .fl, .mv, .ang, .iq, .id);
    always #10 clock = ~clock;
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic test_done();
        if (err_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cyc_n++;
        if (cyc_n == 5000) begin
            err_count++;
            test_done();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask
    // Setup cycle, then access held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic ee);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) begin
            @(posedge clock);
        end
        if (!w) chk($sformatf("read data at %h", a), d, prdata);
        chk($sformatf("pslverr at %h", a), {31'h0, ee}, {31'h0, pslverr});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [31:0] outs();
        return {23'h0, torque_path1_enable, torque_path2_enable, torque_off_state_report,
                card_state, module_shutdown};
    endfunction
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        cyc(4);
        rst_n <= 1'b1;
        cyc(1);
        chk("outputs after reset", 32'h0, outs());
        apb(1'b0, `REG_SAFE_ADDR, 32'h1, 1'b0);
        apb(1'b0, `REG_IMAGE_SIZE, 32'h00020707, 1'b0);
        apb(1'b0, 12'h0fc, 32'h0, 1'b1);
        apb(1'b1, `REG_STATUS, 32'hf, 1'b1);
        apb(1'b0, `REG_CONTROL, 32'h0, 1'b0);
        apb(1'b1, `REG_CONTROL, 32'h1, 1'b0);
        cyc(2);
        chk("enabled outputs", 32'h1c0, outs());
        for (int k = 0; k < 2; k++) begin
            pat <= k ? 8'ha5 : 8'h5a;
            cyc(5);
            apb(1'b0, `REG_IMAGE_FLAGS, {12'h0, pat[6:3], 12'h0, pat[2:1], 1'b1, pat[0]}, 1'b0);
            apb(1'b0, `REG_ENC_ANGLE, {~pat, pat, pat, ~pat}, 1'b0);
            apb(1'b0, `REG_TORQUE_CUR, {pat, 8'h80, ~pat, 8'h01}, 1'b0);
            apb(1'b0, `REG_FIELD_CUR, {~pat, 8'h7f, pat, 8'hfe}, 1'b0);
            apb(1'b0, `REG_DRIVE_REQ, {30'h0, pat[0], pat[7]}, 1'b0);
        end
        module_sw_fault_in <= 4'h4;
        cyc(5);
        module_sw_fault_in <= 4'h0;
        apb(1'b0, `REG_MODULE_ACK, 32'h4, 1'b0);
        apb(1'b1, `REG_MODULE_ACK, 32'h4, 1'b0);
        cyc(2);
        chk("acked modules", 32'h1c0, outs());
        pat <= 8'h5a;
        module_sw_fault_in <= 4'h2;
        cyc(5);
        chk("module two down", 32'h1c2, outs());
        module_sw_fault_in <= 4'h0;
        pat <= 8'ha5;
        cyc(6);
        chk("drive ack clears", 32'h1c0, outs());
        for (int i = 0; i < 4; i++) begin
            rst_n <= 1'b0;
            cyc(2);
            rst_n <= 1'b1;
            apb(1'b1, `REG_CONTROL, 32'h1, 1'b0);
            cyc(2);
            apb(1'b0, `REG_STATUS, 32'h4, 1'b0);
            if (i == 0) supply_fault_in <= 1'b1;
            if (i == 1) selfdiag_fault_in <= 1'b1;
            if (i == 2) encoder_life_expired_in <= 1'b1;
            if (i == 3) apb(1'b1, `REG_FAULT_SET, 32'h8, 1'b0);
            cyc(5);
            {supply_fault_in, selfdiag_fault_in, encoder_life_expired_in} <= 3'b000;
            apb(1'b1, `REG_MODULE_ACK, 32'hf, 1'b0);
            cyc(5);
            chk("shutdown outputs", 32'h010, outs());
            integrity_fault_in <= 1'b1;
            cyc(5);
            integrity_fault_in <= 1'b0;
            apb(1'b1, `REG_MODULE_ACK, 32'hf, 1'b0);
            apb(1'b0, `REG_STATUS, 32'h2, 1'b0);
        end
        test_done();
    end
endmodule
